// ---- logic/lcd_frame_pkg.sv ----
// Shared constants and types for the LCD driver serial frame receiver.
package lcd_frame_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 160;
  localparam int CODE_W = 8;
  localparam int BODY_BITS = 149;
  localparam int DIR_W = 3;
  localparam int CNT_W = 8;
  localparam int CODE_LSB = 152;
  localparam int BODY_LSB = 3;
  localparam int DIR_LSB = 0;
  localparam logic [DIR_W-1:0] DIR_CONTROL = 3'h0;
  localparam logic [DIR_W-1:0] DIR_FIRST_CHUNK = 3'h1;

  // ----------------------------------------------------------------
  // Pin groups and display memory
  // ----------------------------------------------------------------
  localparam int MF_PINS = 9;
  localparam int KEY_DRIVE = 6;
  localparam int KEY_SENSE = 5;
  localparam int BACKPLANE = 4;
  localparam int PAT_CHUNKS = 4;
  localparam int PAT_BITS = PAT_CHUNKS * BODY_BITS;
  localparam int SEG_MAX = 528;
  localparam int IDX_W = 10;

  // ----------------------------------------------------------------
  // Control field positions inside the frame and widths
  // ----------------------------------------------------------------
  localparam int KEYSCAN_LSB = 3;
  localparam int KEYSCAN_W = 3;
  localparam int PORT_LSB = 6;
  localparam int PORT_W = 4;
  localparam int PGSEL_LSB = 10;
  localparam int INV_BIT = 19;
  localparam int BIAS_LSB = 20;
  localparam int BIAS_W = 2;
  localparam int DUTY_LSB = 22;
  localparam int DUTY_W = 3;
  localparam int FRATE_LSB = 25;
  localparam int FRATE_W = 4;
  localparam int TBSRC_BIT = 29;
  localparam int BLANK_BIT = 30;
  localparam int PSAVE_LSB = 31;
  localparam int PSAVE_W = 3;
  localparam int PWMFR_LSB = 34;
  localparam int PWMFR_W = 4;
  localparam int VLCD_LSB = 38;
  localparam int VLCD_W = 4;
  localparam int PWMW_LSB = 42;
  localparam int PWMW_EACH = 9;
  localparam int PWMW_W = MF_PINS * PWMW_EACH;
  localparam int DIV_W = 14;

  // ----------------------------------------------------------------
  // Reset values and code thresholds
  // ----------------------------------------------------------------
  localparam logic [KEYSCAN_W-1:0] KEYSCAN_RST = 3'h7;
  localparam logic [KEYSCAN_W-1:0] KEYSCAN_ALL_SEG = 3'h6;
  localparam logic [PORT_W-1:0] PORT_RST = 4'hF;
  localparam logic [PORT_W-1:0] PORT_MAX = 4'h9;
  localparam logic [MF_PINS-1:0] PGSEL_RST = 9'h000;
  localparam logic INV_RST = 1'h0;
  localparam logic [BIAS_W-1:0] BIAS_RST = 2'h0;
  localparam logic [DUTY_W-1:0] DUTY_RST = 3'h2;
  localparam logic [FRATE_W-1:0] FRATE_RST = 4'h0;
  localparam logic TBSRC_RST = 1'h0;
  localparam logic BLANK_RST = 1'h1;
  localparam logic [PSAVE_W-1:0] PSAVE_RST = 3'h0;
  localparam logic [PWMFR_W-1:0] PWMFR_RST = 4'h0;
  localparam logic [VLCD_W-1:0] VLCD_RST = 4'h0;

  // Frame divisor of the oscillator, indexed by the frame-rate field.
  localparam logic [DIV_W-1:0] FRAME_DIV [16] = '{
    14'h3000, 14'h2A00, 14'h2400, 14'h1E00, 14'h1800, 14'h1200, 14'h0F00, 14'h0C00,
    14'h0B40, 14'h0A80, 14'h09C0, 14'h0900, 14'h0840, 14'h0780, 14'h06C0, 14'h0600};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DUTY_STATIC = 3'b000,
    DUTY_1_3 = 3'b001,
    DUTY_1_4 = 3'b010,
    DUTY_1_5 = 3'b011,
    DUTY_1_7 = 3'b100,
    DUTY_1_8 = 3'b101
  } duty_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FRAME = 2'b01,
    ST_LATCH = 2'b10
  } frame_state_t;

endpackage

// ---- logic/level_sync.sv ----
// Two-stage synchroniser for levels entering the reference clock domain.
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Level in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // level_sync

// ---- logic/frame_shift_in.sv ----
// Link-side shift register and bit counter, clocked by the serial shift clock.
`timescale 1ns/1ps
module frame_shift_in #(
  parameter int FRAME_W = 160,
  parameter int CNT_W = 8
) (
  // Serial link
  input wire logic shiftClk,
  input wire logic chip_select_in,
  input wire logic serial_in,
  // Captured frame, stable while chip-select is low
  output logic [FRAME_W-1:0] frameBits,
  output logic [CNT_W-1:0] bitCount
);

  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(FRAME_W + 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic fresh;

  // The shift clock may stop outside frames, so the start of a frame is
  // marked by chip-select itself rather than by a clock edge.
  always_ff @(posedge shiftClk or negedge chip_select_in) begin
    if (!chip_select_in) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Rising edge sampling works whether the clock rests low or high.
  always_ff @(posedge shiftClk) begin
    if (chip_select_in) begin
      frameBits <= {frameBits[FRAME_W-2:0], serial_in};
      if (fresh) begin
        bitCount <= CNT_ONE;
      end else if (bitCount != CNT_MAX) begin
        bitCount <= bitCount + CNT_ONE;
      end
    end
  end

endmodule // frame_shift_in

// ---- logic/lcd_driver_serial_frame_receiver.sv ----
// Serial command-frame receiver and control latch of a segment LCD driver.
`timescale 1ns/1ps
module lcd_driver_serial_frame_receiver #(
  // Arbitrary value; the identification code is set per product.
  parameter logic [lcd_frame_pkg::CODE_W-1:0] DEVICE_CODE = 8'h5A
) (
  // Reference clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Serial link
  input wire logic shiftClk,
  input wire logic chip_select_in,
  input wire logic serial_in,
  // Frame status
  output logic frameAccepted,
  output logic frameRejected,
  output logic [lcd_frame_pkg::DIR_W-1:0] direction_bits,
  // Latched control fields
  output logic [lcd_frame_pkg::KEYSCAN_W-1:0] keyscan_pin_select,
  output logic [lcd_frame_pkg::PORT_W-1:0] port_function_select,
  output logic [lcd_frame_pkg::MF_PINS-1:0] pwm_or_gpo_select,
  output logic inversion_select,
  output logic [lcd_frame_pkg::BIAS_W-1:0] bias_select,
  output logic [lcd_frame_pkg::DUTY_W-1:0] duty_select,
  output logic [lcd_frame_pkg::FRATE_W-1:0] frame_rate_divider,
  output logic timebase_source_sel,
  output logic segment_blank_ctl,
  output logic [lcd_frame_pkg::PSAVE_W-1:0] power_save_mode,
  output logic [lcd_frame_pkg::PWMFR_W-1:0] pwm_frame_rate,
  output logic [lcd_frame_pkg::VLCD_W-1:0] lcd_voltage_level,
  output logic [lcd_frame_pkg::PWMW_W-1:0] pwm_width_setting,
  // Display memory
  output logic [lcd_frame_pkg::SEG_MAX-1:0] segment_pattern_bits,
  // Derived pin functions
  output logic [lcd_frame_pkg::BACKPLANE-1:0] backplaneIsCommon,
  output logic [lcd_frame_pkg::KEY_DRIVE-1:0] keyDriveIsSegment,
  output logic [lcd_frame_pkg::KEY_SENSE-1:0] keySenseIsSegment,
  output logic [lcd_frame_pkg::MF_PINS-1:0] mfPinIsPort,
  output logic [lcd_frame_pkg::MF_PINS-1:0] mfPinIsPwm,
  output logic [lcd_frame_pkg::MF_PINS-1:0] gpoLevel,
  output logic extTimebaseIsInput,
  output logic powerSaveActive,
  output logic [lcd_frame_pkg::DIV_W-1:0] frameDivRatio,
  output logic [lcd_frame_pkg::IDX_W-1:0] segmentCount
);
  import lcd_frame_pkg::*;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------

  // Codes outside the table fall back to 1/4 duty.
  function automatic duty_t normDuty(input logic [DUTY_W-1:0] code);
    duty_t res;
    unique case (code)
      3'b000: res = DUTY_STATIC;
      3'b001: res = DUTY_1_3;
      3'b011: res = DUTY_1_5;
      3'b100: res = DUTY_1_7;
      3'b101: res = DUTY_1_8;
      default: res = DUTY_1_4;
    endcase
    return res;
  endfunction

  function automatic logic [IDX_W-1:0] segCount(input duty_t d);
    logic [IDX_W-1:0] res;
    unique case (d)
      DUTY_1_8: res = IDX_W'(528);
      DUTY_1_7: res = IDX_W'(469);
      DUTY_1_5: res = IDX_W'(345);
      DUTY_1_4: res = IDX_W'(280);
      DUTY_1_3: res = IDX_W'(210);
      DUTY_STATIC: res = IDX_W'(70);
    endcase
    return res;
  endfunction

  // Spacing in the pattern between the bits that the port pins follow.
  function automatic logic [IDX_W-1:0] gpoStep(input duty_t d);
    logic [IDX_W-1:0] res;
    unique case (d)
      DUTY_1_8: res = IDX_W'(8);
      DUTY_1_7: res = IDX_W'(7);
      DUTY_1_5: res = IDX_W'(5);
      DUTY_1_4: res = IDX_W'(4);
      DUTY_1_3: res = IDX_W'(3);
      DUTY_STATIC: res = IDX_W'(1);
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Link side and crossing
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] frameBits;
  logic [CNT_W-1:0] bitCount;
  logic csSync;

  // Bits move only while chip-select is high; clock rest level is free.
  frame_shift_in #(
    .FRAME_W(FRAME_BITS),
    .CNT_W(CNT_W)
  ) uShift (
    .shiftClk(shiftClk),
    .chip_select_in(chip_select_in),
    .serial_in(serial_in),
    .frameBits(frameBits),
    .bitCount(bitCount)
  );

  // The frame word itself is not synchronised: it is frozen while
  // chip-select is low, and the synchronised fall acts as the handshake.
  level_sync #(
    .W(1)
  ) uCsSync (
    .clk(ref_clk),
    .srst(srst),
    .d(chip_select_in),
    .q(csSync)
  );

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  frame_state_t state;
  frame_state_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (csSync) begin
          next_state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (!csSync) begin
          next_state = ST_LATCH;
        end
      end
      ST_LATCH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Frame checks
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] rxCode;
  logic [DIR_W-1:0] rxDir;
  logic [IDX_W-1:0] chunkStart;
  logic lengthOk;
  logic codeOk;
  logic isControl;
  logic chunkOk;
  logic latchNow;
  logic accept;
  duty_t dutyNow;

  assign dutyNow = normDuty(duty_select);
  assign rxCode = frameBits[CODE_LSB +: CODE_W];
  assign rxDir = frameBits[DIR_LSB +: DIR_W];
  assign chunkStart = IDX_W'(rxDir - DIR_FIRST_CHUNK) * IDX_W'(BODY_BITS);
  assign lengthOk = (bitCount == CNT_W'(FRAME_BITS));
  assign codeOk = (rxCode == DEVICE_CODE);
  assign isControl = (rxDir == DIR_CONTROL);
  // A pattern chunk counts only if it starts inside the current duty's span.
  assign chunkOk = (rxDir >= DIR_FIRST_CHUNK) && (rxDir <= DIR_W'(PAT_CHUNKS))
    && (chunkStart < segCount(dutyNow));
  assign latchNow = (state == ST_LATCH);
  assign accept = latchNow && lengthOk && codeOk && (isControl || chunkOk);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      frameAccepted <= 1'b0;
      frameRejected <= 1'b0;
    end else begin
      frameAccepted <= accept;
      frameRejected <= latchNow && !accept;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      direction_bits <= DIR_CONTROL;
    end else if (accept) begin
      direction_bits <= rxDir;
    end
  end

  // ----------------------------------------------------------------
  // Control latch
  // ----------------------------------------------------------------
  // All fields change in the same cycle, so the drive logic never sees a
  // half-updated mix of old and new settings.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      keyscan_pin_select <= KEYSCAN_RST;
      port_function_select <= PORT_RST;
      pwm_or_gpo_select <= PGSEL_RST;
      inversion_select <= INV_RST;
      bias_select <= BIAS_RST;
      duty_select <= DUTY_RST;
      frame_rate_divider <= FRATE_RST;
      timebase_source_sel <= TBSRC_RST;
      segment_blank_ctl <= BLANK_RST;
      power_save_mode <= PSAVE_RST;
      pwm_frame_rate <= PWMFR_RST;
      lcd_voltage_level <= VLCD_RST;
      pwm_width_setting <= '0;
    end else if (accept && isControl) begin
      keyscan_pin_select <= frameBits[KEYSCAN_LSB +: KEYSCAN_W];
      port_function_select <= frameBits[PORT_LSB +: PORT_W];
      pwm_or_gpo_select <= frameBits[PGSEL_LSB +: MF_PINS];
      inversion_select <= frameBits[INV_BIT];
      bias_select <= frameBits[BIAS_LSB +: BIAS_W];
      duty_select <= frameBits[DUTY_LSB +: DUTY_W];
      frame_rate_divider <= frameBits[FRATE_LSB +: FRATE_W];
      timebase_source_sel <= frameBits[TBSRC_BIT];
      segment_blank_ctl <= frameBits[BLANK_BIT];
      power_save_mode <= frameBits[PSAVE_LSB +: PSAVE_W];
      pwm_frame_rate <= frameBits[PWMFR_LSB +: PWMFR_W];
      lcd_voltage_level <= frameBits[VLCD_LSB +: VLCD_W];
      pwm_width_setting <= frameBits[PWMW_LSB +: PWMW_W];
    end
  end

  // ----------------------------------------------------------------
  // Display memory
  // ----------------------------------------------------------------
  logic [PAT_BITS-1:0] segPattern;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      segPattern <= '0;
    end else if (accept && !isControl) begin
      segPattern[chunkStart +: BODY_BITS] <= frameBits[BODY_LSB +: BODY_BITS];
    end
  end

  assign segment_pattern_bits = segPattern[SEG_MAX-1:0];

  // ----------------------------------------------------------------
  // Pin functions
  // ----------------------------------------------------------------
  // These follow the latched settings one cycle later.
  logic [PORT_W-1:0] portCount;

  assign portCount = (port_function_select <= PORT_MAX) ? port_function_select : '0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      backplaneIsCommon <= '0;
    end else begin
      backplaneIsCommon <= {BACKPLANE{dutyNow inside {DUTY_1_5, DUTY_1_7, DUTY_1_8}}};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      keySenseIsSegment <= '0;
    end else begin
      keySenseIsSegment <= {KEY_SENSE{keyscan_pin_select >= KEYSCAN_ALL_SEG}};
    end
  end

  genvar gk;
  generate
    for (gk = 0; gk < KEY_DRIVE; gk++) begin : gKeyDrive
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          keyDriveIsSegment[gk] <= 1'b0;
        end else begin
          keyDriveIsSegment[gk] <= (keyscan_pin_select > KEYSCAN_W'(gk));
        end
      end
    end
  endgenerate

  genvar gm;
  generate
    for (gm = 0; gm < MF_PINS; gm++) begin : gMultiPin
      logic isPort;
      logic [IDX_W-1:0] bitIdx;
      assign isPort = (portCount > PORT_W'(gm));
      assign bitIdx = IDX_W'(gm) * gpoStep(dutyNow);
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          mfPinIsPort[gm] <= 1'b0;
          mfPinIsPwm[gm] <= 1'b0;
          gpoLevel[gm] <= 1'b0;
        end else begin
          mfPinIsPort[gm] <= isPort;
          mfPinIsPwm[gm] <= isPort && pwm_or_gpo_select[gm];
          gpoLevel[gm] <= isPort && !pwm_or_gpo_select[gm] && segPattern[bitIdx];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      extTimebaseIsInput <= TBSRC_RST;
      powerSaveActive <= 1'b0;
    end else begin
      extTimebaseIsInput <= timebase_source_sel;
      powerSaveActive <= (power_save_mode != PSAVE_RST);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      frameDivRatio <= FRAME_DIV[FRATE_RST];
      segmentCount <= segCount(normDuty(DUTY_RST));
    end else begin
      frameDivRatio <= FRAME_DIV[frame_rate_divider];
      segmentCount <= segCount(dutyNow);
    end
  end

endmodule // lcd_driver_serial_frame_receiver

// ---- dv/frame_master.sv ----
// Serial master model that shifts command frames into the receiver.
`timescale 1ns/1ps
module frame_master (
  // Serial link driven toward the receiver
  output logic shiftClk,
  output logic chip_select_in,
  output logic serial_in
);
  initial begin
    shiftClk = 1'b0;
    chip_select_in = 1'b0;
    serial_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame transfer
  // ----------------------------------------------------------------
  // The clock stands still between frames at the chosen rest level.
  task automatic send(input logic [159:0] word, input int nbits, input logic idleHigh);
    int i;
    shiftClk = idleHigh;
    #125;
    chip_select_in = 1'b1;
    #125;
    for (i = 0; i < nbits; i++) begin
      shiftClk = 1'b0;
      serial_in = word[159-i];
      #62.5;
      shiftClk = 1'b1;
      #62.5;
    end
    shiftClk = idleHigh;
    #125;
    chip_select_in = 1'b0;
    // A released data line must not keep showing the last bit.
    serial_in = ~serial_in;
  endtask
endmodule // frame_master

// ---- dv/lcd_frame_receiver_asserts.sv ----
// Concurrent checks on the ports of the serial frame receiver.
`timescale 1ns/1ps
module lcd_frame_receiver_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Observed ports
  input wire logic chip_select_in,
  input wire logic frameAccepted,
  input wire logic frameRejected,
  input wire logic [lcd_frame_pkg::KEYSCAN_W-1:0] keyscan_pin_select,
  input wire logic [lcd_frame_pkg::MF_PINS-1:0] pwm_or_gpo_select,
  input wire logic [lcd_frame_pkg::DUTY_W-1:0] duty_select,
  input wire logic timebase_source_sel,
  input wire logic [lcd_frame_pkg::PSAVE_W-1:0] power_save_mode,
  input wire logic [lcd_frame_pkg::SEG_MAX-1:0] segment_pattern_bits,
  input wire logic [lcd_frame_pkg::BACKPLANE-1:0] backplaneIsCommon,
  input wire logic [lcd_frame_pkg::KEY_SENSE-1:0] keySenseIsSegment,
  input wire logic [lcd_frame_pkg::MF_PINS-1:0] mfPinIsPort,
  input wire logic [lcd_frame_pkg::MF_PINS-1:0] mfPinIsPwm,
  input wire logic extTimebaseIsInput,
  input wire logic powerSaveActive
);
  import lcd_frame_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pulse_excl_a: assert property (!(frameAccepted && frameRejected))
    else $error("accept and reject pulses together");
  accept_pulse_a: assert property (frameAccepted |=> !frameAccepted && !frameRejected)
    else $error("accept pulse longer than one cycle");
  after_fall_a: assert property (frameAccepted |-> !$past(chip_select_in, 3))
    else $error("accept without chip select low");
  fields_hold_a: assert property ($changed(duty_select) || $changed(keyscan_pin_select) |-> frameAccepted)
    else $error("control field changed without accepted frame");
  pattern_hold_a: assert property ($changed(segment_pattern_bits) |-> frameAccepted)
    else $error("pattern changed without accepted frame");
  backplane_map_a: assert property (1'b1 |=> backplaneIsCommon ==
    ($past(duty_select) inside {3'h3, 3'h4, 3'h5} ? 4'hF : 4'h0))
    else $error("backplane function does not follow duty");
  key_sense_a: assert property (1'b1 |=> keySenseIsSegment ==
    ($past(keyscan_pin_select) >= 3'h6 ? 5'h1F : 5'h00))
    else $error("key sense function does not follow key scan field");
  pwm_pick_a: assert property (1'b1 |=> mfPinIsPwm == (mfPinIsPort & $past(pwm_or_gpo_select)))
    else $error("pwm pins do not follow select field");
  ext_clock_a: assert property (1'b1 |=> extTimebaseIsInput == $past(timebase_source_sel))
    else $error("timebase pin function does not follow source bit");
  power_save_a: assert property (1'b1 |=> powerSaveActive == ($past(power_save_mode) != 3'h0))
    else $error("power save flag does not follow mode field");
endmodule // lcd_frame_receiver_asserts

bind lcd_driver_serial_frame_receiver lcd_frame_receiver_asserts u_chk (
  .ref_clk(ref_clk), .srst(srst), .chip_select_in(chip_select_in),
  .frameAccepted(frameAccepted), .frameRejected(frameRejected),
  .keyscan_pin_select(keyscan_pin_select), .pwm_or_gpo_select(pwm_or_gpo_select),
  .duty_select(duty_select), .timebase_source_sel(timebase_source_sel),
  .power_save_mode(power_save_mode), .segment_pattern_bits(segment_pattern_bits),
  .backplaneIsCommon(backplaneIsCommon), .keySenseIsSegment(keySenseIsSegment),
  .mfPinIsPort(mfPinIsPort), .mfPinIsPwm(mfPinIsPwm),
  .extTimebaseIsInput(extTimebaseIsInput), .powerSaveActive(powerSaveActive));

// ---- dv/lcd_driver_serial_frame_receiver_bench.sv ----
// Self-checking bench for the serial frame receiver.
`timescale 1ns/1ps
module lcd_driver_serial_frame_receiver_bench;
  import lcd_frame_pkg::*;
  // Arbitrary identification code used only by this bench.
  localparam logic [CODE_W-1:0] CODE = 8'hA6;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic shiftClk, chip_select_in, serial_in, frameAccepted, frameRejected;
  logic inversion_select, timebase_source_sel, segment_blank_ctl;
  logic extTimebaseIsInput, powerSaveActive;
  logic [DIR_W-1:0] direction_bits;
  logic [KEYSCAN_W-1:0] keyscan_pin_select;
  logic [PORT_W-1:0] port_function_select;
  logic [MF_PINS-1:0] pwm_or_gpo_select, mfPinIsPort, mfPinIsPwm, gpoLevel;
  logic [BIAS_W-1:0] bias_select;
  logic [DUTY_W-1:0] duty_select;
  logic [FRATE_W-1:0] frame_rate_divider;
  logic [PSAVE_W-1:0] power_save_mode;
  logic [PWMFR_W-1:0] pwm_frame_rate;
  logic [VLCD_W-1:0] lcd_voltage_level;
  logic [PWMW_W-1:0] pwm_width_setting;
  logic [SEG_MAX-1:0] segment_pattern_bits;
  logic [BACKPLANE-1:0] backplaneIsCommon;
  logic [KEY_DRIVE-1:0] keyDriveIsSegment;
  logic [KEY_SENSE-1:0] keySenseIsSegment;
  logic [DIV_W-1:0] frameDivRatio;
  logic [IDX_W-1:0] segmentCount;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  frame_master u_master (.shiftClk(shiftClk), .chip_select_in(chip_select_in),
    .serial_in(serial_in));

  lcd_driver_serial_frame_receiver #(.DEVICE_CODE(CODE)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .shiftClk(shiftClk), .chip_select_in(chip_select_in),
    .serial_in(serial_in), .frameAccepted(frameAccepted), .frameRejected(frameRejected),
    .direction_bits(direction_bits), .keyscan_pin_select(keyscan_pin_select),
    .port_function_select(port_function_select), .pwm_or_gpo_select(pwm_or_gpo_select),
    .inversion_select(inversion_select), .bias_select(bias_select),
    .duty_select(duty_select), .frame_rate_divider(frame_rate_divider),
    .timebase_source_sel(timebase_source_sel), .segment_blank_ctl(segment_blank_ctl),
    .power_save_mode(power_save_mode), .pwm_frame_rate(pwm_frame_rate),
    .lcd_voltage_level(lcd_voltage_level), .pwm_width_setting(pwm_width_setting),
    .segment_pattern_bits(segment_pattern_bits), .backplaneIsCommon(backplaneIsCommon),
    .keyDriveIsSegment(keyDriveIsSegment), .keySenseIsSegment(keySenseIsSegment),
    .mfPinIsPort(mfPinIsPort), .mfPinIsPwm(mfPinIsPwm), .gpoLevel(gpoLevel),
    .extTimebaseIsInput(extTimebaseIsInput), .powerSaveActive(powerSaveActive),
    .frameDivRatio(frameDivRatio), .segmentCount(segmentCount));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [527:0] got, input logic [527:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Sends a frame, waits for the expected status pulse, then keeps the idle gap.
  task automatic xfer(input logic [159:0] w, input int n, input logic hi, input logic acc);
    int k;
    logic seen;
    u_master.send(w, n, hi);
    seen = 1'b0;
    k = 0;
    while (!seen && k < 12) begin
      @(posedge ref_clk);
      #1;
      k++;
      if ((acc ? frameAccepted : frameRejected) === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b1);
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [159:0] ctrl(input logic [2:0] ks, input logic [3:0] pt,
    input logic [8:0] pg, input logic [2:0] dt);
    logic [159:0] w;
    w = '0;
    w[CODE_LSB +: CODE_W] = CODE;
    w[KEYSCAN_LSB +: KEYSCAN_W] = ks;
    w[PORT_LSB +: PORT_W] = pt;
    w[PGSEL_LSB +: MF_PINS] = pg;
    w[INV_BIT] = 1'b1;
    w[BIAS_LSB +: BIAS_W] = 2'h3;
    w[DUTY_LSB +: DUTY_W] = dt;
    w[FRATE_LSB +: FRATE_W] = 4'h7;
    w[TBSRC_BIT] = 1'b1;
    w[PSAVE_LSB +: PSAVE_W] = 3'h5;
    w[PWMFR_LSB +: PWMFR_W] = 4'hA;
    w[VLCD_LSB +: VLCD_W] = 4'hC;
    w[PWMW_LSB +: PWMW_W] = {9{9'h1A5}};
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({keyscan_pin_select, port_function_select, duty_select, segment_blank_ctl}, 11'h7F5);
    chk({segmentCount, frameDivRatio}, {10'h118, 14'h3000});
    chk({keyDriveIsSegment, keySenseIsSegment, backplaneIsCommon, mfPinIsPort},
      24'hFFE000);
    chk(segment_pattern_bits, '0);
  endtask

  task automatic t_control;
    xfer(ctrl(3'h3, 4'h4, 9'h005, 3'h5), 160, 1'b0, 1'b1);
    chk(keyscan_pin_select, 3'h3);
    chk({port_function_select, pwm_or_gpo_select}, {4'h4, 9'h005});
    chk({inversion_select, bias_select}, 3'h7);
    chk({duty_select, frame_rate_divider, frameDivRatio}, {3'h5, 4'h7, 14'h0C00});
    chk({timebase_source_sel, extTimebaseIsInput}, 2'h3);
    chk(segment_blank_ctl, 1'b0);
    chk({power_save_mode, powerSaveActive}, 4'hB);
    chk({pwm_frame_rate, pwm_width_setting}, {4'hA, {9{9'h1A5}}});
    chk(lcd_voltage_level, 4'hC);
    chk({keyDriveIsSegment, keySenseIsSegment}, {6'h07, 5'h00});
    chk({mfPinIsPort, mfPinIsPwm}, {9'h00F, 9'h005});
    chk({backplaneIsCommon, segmentCount, direction_bits}, {4'hF, 10'h210, 3'h0});
  endtask

  task automatic t_reject;
    logic [159:0] w;
    w = ctrl(3'h1, 4'h0, 9'h000, 3'h0);
    xfer(w ^ {8'h01, 152'h0}, 160, 1'b0, 1'b0);
    xfer(w, 159, 1'b1, 1'b0);
    xfer(w | 160'h7, 160, 1'b0, 1'b0);
    chk({duty_select, keyscan_pin_select}, {3'h5, 3'h3});
  endtask

  task automatic t_duty;
    logic [9:0] segs [8] = '{10'd70, 10'd210, 10'd280, 10'd345, 10'd469, 10'd528,
      10'd280, 10'd280};
    int d;
    for (d = 0; d < 8; d++) begin
      xfer(ctrl(3'h6, 4'h0, 9'h000, d[2:0]), 160, d[0], 1'b1);
      chk(segmentCount, segs[d]);
      chk(backplaneIsCommon, (d >= 3 && d <= 5) ? 4'hF : 4'h0);
      chk({keyDriveIsSegment, keySenseIsSegment}, 11'h7FF);
    end
  endtask

  task automatic t_pattern;
    logic [148:0] body;
    logic [8:0] gexp;
    int i;
    body = {4'hB, {4{36'h9C3A5F01E}}, 1'b1};
    xfer(ctrl(3'h0, 4'h9, 9'h000, 3'h2), 160, 1'b1, 1'b1);
    xfer({CODE, body, 3'h1}, 160, 1'b0, 1'b1);
    for (i = 0; i < 9; i++) gexp[i] = body[i*4];
    chk(segment_pattern_bits[148:0], body);
    chk({mfPinIsPort, mfPinIsPwm, gpoLevel}, {9'h1FF, 9'h000, gexp});
    chk({duty_select, direction_bits}, {3'h2, 3'h1});
  endtask

  // ----------------------------------------------------------------
  // Closing
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang anywhere ends the run; the full sequence needs about 3000 cycles.
  initial begin
    forever begin
      @(posedge ref_clk);
      cycles++;
      if (cycles >= 20000) begin
        n_mismatch++;
        test_done();
      end
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    t_reset();
    t_control();
    t_reject();
    t_duty();
    t_pattern();
    test_done();
  end
endmodule // lcd_driver_serial_frame_receiver_bench
